//--- sfd_pkg.sv
// Package: register map, field layout and types of the serial data block
package sfd_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam int          ADDR_W   = 8;
	localparam logic [7:0]  OFF_RSW  = 8'h00;
	localparam logic [7:0]  OFF_TCW  = 8'h04;
	localparam logic [7:0]  OFF_RCW  = 8'h08;
	localparam logic [7:0]  OFF_MODE = 8'h0C;
	localparam logic [7:0]  OFF_CTRL = 8'h10;
	localparam logic [7:0]  OFF_RXSA = 8'h14;
	localparam logic [7:0]  OFF_CDSA = 8'h18;

	typedef enum logic [2:0] {
		SEL_RSW  = 3'h0,
		SEL_TCW  = 3'h1,
		SEL_RCW  = 3'h2,
		SEL_MODE = 3'h3,
		SEL_CTRL = 3'h4,
		SEL_RXSA = 3'h5,
		SEL_CDSA = 3'h6,
		SEL_NONE = 3'h7
	} sfd_sel_t;

	// ==========================================================
	// Field layout and reset values
	localparam logic [31:0] ZERO_W    = 32'h0000_0000;
	localparam logic [31:0] TCW_RST   = 32'h0000_0000;
	localparam logic [31:0] RCW_RST   = 32'h0000_0000;
	localparam logic [31:0] MODE_MASK = 32'h0000_010F;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
	localparam logic [31:0] SA_MASK   = 32'h0000_8383;
	localparam int FL_LSB   = 0;
	localparam int FL_MSB   = 3;
	localparam int STOP_BIT = 8;
	localparam int RECEIVE_RESET_BIT_BIT = 0;
	localparam int RXE_BIT  = 1;
	localparam int TXE_BIT  = 2;
	localparam int POSA_LSB = 0;
	localparam int ENA_BIT  = 7;
	localparam int POSB_LSB = 8;
	localparam int ENB_BIT  = 15;
	localparam int HI_LSB   = 16;
	localparam int HALF_W   = 16;

	// ==========================================================
	// Frame layout: 16-bit slots, 2 slots short frame, 4 long
	localparam logic [3:0]  SLOT_LAST      = 4'hF;
	localparam logic [5:0]  LAST_BIT_SHORT = 6'h1F;
	localparam logic [5:0]  LAST_BIT_LONG  = 6'h3F;
	localparam logic [5:0]  BIT_FIRST      = 6'h00;
	localparam logic [5:0]  BIT_STEP       = 6'h01;
	localparam int          FIFO_AW        = 2;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		LNK_IDLE  = 2'h1,
		LNK_FRAME = 2'h2
	} sfd_link_t;

	typedef struct packed {
		logic [3:0] frame_length_field;
		logic       stop;
		logic       receive_reset_bit;
		logic       rx_en;
		logic       tx_en;
		logic [1:0] left_rx_slot_pos;
		logic       left_rx_enable;
		logic [1:0] right_rx_slot_pos;
		logic       right_rx_enable;
		logic [1:0] ctrl_zero_slot_pos;
		logic       ctrl_zero_enable;
		logic [1:0] ctrl_one_slot_pos;
		logic       ctrl_one_enable;
	} sfd_cfg_t;

	// Slot match for one channel
	function automatic logic sfd_hit(input logic [1:0] slot,
		input logic [1:0] pos, input logic en);
		return en && (slot == pos);
	endfunction

	function automatic sfd_sel_t sfd_decode(input logic [7:0] a);
		case (a)
			OFF_RSW:  return SEL_RSW;
			OFF_TCW:  return SEL_TCW;
			OFF_RCW:  return SEL_RCW;
			OFF_MODE: return SEL_MODE;
			OFF_CTRL: return SEL_CTRL;
			OFF_RXSA: return SEL_RXSA;
			OFF_CDSA: return SEL_CDSA;
			default:  return SEL_NONE;
		endcase
	endfunction

endpackage

//--- sfd_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = ce ? d : meta;
		next_q    = ce ? meta : q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end
endmodule // sfd_sync
`default_nettype wire

//--- sfd_rx_fifo.sv
// Receive sample FIFO holding left/right pairs
`timescale 1ns/1ps
`default_nettype none
module sfd_rx_fifo
	import sfd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        clr,
	// Write side
	input  wire logic        push,
	input  wire logic [31:0] push_data,
	// Read side
	input  wire logic        pop,
	output logic      [31:0] head,
	output logic             empty,
	output logic             full
);
	localparam int DEPTH = 1 << FIFO_AW;
	localparam logic [FIFO_AW:0] PTR_ONE = 1;

	logic [31:0]      mem [DEPTH];
	logic [FIFO_AW:0] wr_ptr;
	logic [FIFO_AW:0] rd_ptr;
	logic [FIFO_AW:0] next_wr_ptr;
	logic [FIFO_AW:0] next_rd_ptr;
	logic             do_push;

	assign empty = (wr_ptr == rd_ptr);
	assign full  = (wr_ptr[FIFO_AW-1:0] == rd_ptr[FIFO_AW-1:0]) &&
		(wr_ptr[FIFO_AW] != rd_ptr[FIFO_AW]);
	assign head  = mem[rd_ptr[FIFO_AW-1:0]];
	assign do_push = ce && push && !full && !clr;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (ce) begin
			if (clr) begin
				next_wr_ptr = '0;
				next_rd_ptr = '0;
			end else begin
				if (do_push)
					next_wr_ptr = wr_ptr + PTR_ONE;
				if (pop && !empty)
					next_rd_ptr = rd_ptr + PTR_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage is not reset: contents are undefined after reset
	always_ff @(posedge clk) begin
		if (do_push)
			mem[wr_ptr[FIFO_AW-1:0]] <= push_data;
	end
endmodule // sfd_rx_fifo
`default_nettype wire

//--- sfd_top.sv
// Serial port data and control-data registers with AXI4-Lite access
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sfd_top
	import sfd_pkg::*;
(
	// Clock, reset, clock enable
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	input  wire logic              CE,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	// Serial link
	input  wire logic              SERIAL_CLK,
	input  wire logic              FRAME_SYNC,
	input  wire logic              SERIAL_RX_PIN,
	output logic                   SERIAL_TX_PIN
);
	// ==========================================================
	// Declarations
	logic [31:0] tcw, rcw, mode_reg, ctrl_reg, rxsa_reg, cdsa_reg;
	logic [31:0] next_tcw, next_rcw, next_mode, next_ctrl;
	logic [31:0] next_rxsa, next_cdsa;
	logic [15:0] left_hold, right_hold, next_left, next_right;
	logic [15:0] rx_shift, next_shift;
	logic        aw_full, w_full, next_aw_full, next_w_full;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_awready, next_wready, next_bvalid, next_arready;
	logic        next_rvalid, next_tx;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        sck_s, sync_s, rxd_s, sck_q, next_sck_q;
	logic        sck_rise, sck_fall;
	sfd_link_t   lstate, next_lstate;
	logic [5:0]  bit_cnt, next_bit_cnt, idx, tx_idx, last_bit;
	logic [1:0]  slot, tx_slot;
	logic [3:0]  sbit, tx_sbit;
	logic        sample, slot_done, rx_active, long_frame;
	logic [15:0] rx_word;
	logic        fifo_push, fifo_pop, fifo_empty;
	logic [31:0] fifo_head;
	logic        do_write;
	sfd_sel_t    wsel, rsel;
	sfd_cfg_t    cfg;

	// ==========================================================
	// Configuration view of the control registers
	assign cfg.frame_length_field = mode_reg[FL_MSB:FL_LSB];
	assign cfg.stop               = mode_reg[STOP_BIT];
	assign cfg.receive_reset_bit  = ctrl_reg[RECEIVE_RESET_BIT_BIT];
	assign cfg.rx_en              = ctrl_reg[RXE_BIT];
	assign cfg.tx_en              = ctrl_reg[TXE_BIT];
	assign cfg.left_rx_slot_pos   = rxsa_reg[POSA_LSB +: 2];
	assign cfg.left_rx_enable     = rxsa_reg[ENA_BIT];
	assign cfg.right_rx_slot_pos  = rxsa_reg[POSB_LSB +: 2];
	assign cfg.right_rx_enable    = rxsa_reg[ENB_BIT];
	assign cfg.ctrl_zero_slot_pos = cdsa_reg[POSA_LSB +: 2];
	assign cfg.ctrl_zero_enable   = cdsa_reg[ENA_BIT];
	assign cfg.ctrl_one_slot_pos  = cdsa_reg[POSB_LSB +: 2];
	assign cfg.ctrl_one_enable    = cdsa_reg[ENB_BIT];

	assign long_frame = cfg.frame_length_field[FL_MSB - FL_LSB];
	assign last_bit   = long_frame ? LAST_BIT_LONG : LAST_BIT_SHORT;
	assign rx_active  = cfg.rx_en && !cfg.receive_reset_bit &&
		!cfg.stop;

	// ==========================================================
	// Pin synchronisers and serial clock edges
	sfd_sync #(.W(3)) u_sync (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.ce    (CE),
		.d     ({SERIAL_CLK, FRAME_SYNC, SERIAL_RX_PIN}),
		.q     ({sck_s, sync_s, rxd_s})
	);

	assign sck_rise = CE && sck_s && !sck_q;
	assign sck_fall = CE && !sck_s && sck_q;

	// ==========================================================
	// Frame position
	assign sample    = sck_rise && ((lstate == LNK_FRAME) || sync_s);
	assign idx       = (lstate == LNK_FRAME) ? bit_cnt : BIT_FIRST;
	assign slot      = idx[5:4];
	assign sbit      = idx[3:0];
	assign slot_done = sample && (sbit == SLOT_LAST);
	assign rx_word   = {rx_shift[14:0], rxd_s};
	assign tx_idx    = idx;
	assign tx_slot   = tx_idx[5:4];
	assign tx_sbit   = tx_idx[3:0];

	always_comb begin
		next_lstate  = lstate;
		next_bit_cnt = bit_cnt;
		next_sck_q   = CE ? sck_s : sck_q;
		case (lstate)
			LNK_IDLE: begin
				if (sample && !cfg.stop) begin
					next_lstate  = LNK_FRAME;
					next_bit_cnt = BIT_STEP;
				end
			end
			LNK_FRAME: begin
				if (cfg.stop) begin
					next_lstate  = LNK_IDLE;
					next_bit_cnt = BIT_FIRST;
				end else if (sample) begin
					if (idx >= last_bit) begin
						next_lstate  = LNK_IDLE;
						next_bit_cnt = BIT_FIRST;
					end else begin
						next_bit_cnt = idx + BIT_STEP;
					end
				end
			end
			default: begin
				next_lstate  = LNK_IDLE;
				next_bit_cnt = BIT_FIRST;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			lstate  <= LNK_IDLE;
			bit_cnt <= BIT_FIRST;
			sck_q   <= 1'b0;
		end else begin
			lstate  <= next_lstate;
			bit_cnt <= next_bit_cnt;
			sck_q   <= next_sck_q;
		end
	end

	// ==========================================================
	// Receive capture into sample pair and control word
	always_comb begin
		next_shift = sample ? rx_word : rx_shift;
		next_left  = left_hold;
		next_right = right_hold;
		next_rcw   = rcw;
		fifo_push  = 1'b0;
		if (!rx_active) begin
			if (cfg.receive_reset_bit) begin
				next_left  = '0;
				next_right = '0;
				next_rcw   = RCW_RST;
			end
		end else if (slot_done) begin
			if (sfd_hit(slot, cfg.left_rx_slot_pos, cfg.left_rx_enable))
				next_left = rx_word;
			if (sfd_hit(slot, cfg.right_rx_slot_pos,
				cfg.right_rx_enable))
				next_right = rx_word;
			if (long_frame && sfd_hit(slot, cfg.ctrl_zero_slot_pos,
				cfg.ctrl_zero_enable))
				next_rcw[31:HI_LSB] = rx_word;
			if (long_frame && sfd_hit(slot, cfg.ctrl_one_slot_pos,
				cfg.ctrl_one_enable))
				next_rcw[HALF_W-1:0] = rx_word;
			if (idx >= last_bit)
				fifo_push = cfg.left_rx_enable || cfg.right_rx_enable;
		end
	end

	sfd_rx_fifo u_fifo (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.ce        (CE),
		.clr       (cfg.receive_reset_bit),
		.push      (fifo_push),
		.push_data ({next_left, next_right}),
		.pop       (fifo_pop),
		.head      (fifo_head),
		.empty     (fifo_empty),
		.full      ()
	);

	// ==========================================================
	// Transmit pin: control channels in their slots, else high
	always_comb begin
		next_tx = SERIAL_TX_PIN;
		if (sck_fall || (CE && lstate == LNK_IDLE)) begin
			next_tx = 1'b1;
			if (cfg.tx_en && long_frame && !cfg.stop) begin
				if (sfd_hit(tx_slot, cfg.ctrl_zero_slot_pos,
					cfg.ctrl_zero_enable))
					next_tx = tcw[31 - tx_sbit];
				else if (sfd_hit(tx_slot, cfg.ctrl_one_slot_pos,
					cfg.ctrl_one_enable))
					next_tx = tcw[HALF_W - 1 - tx_sbit];
			end
		end
	end

	// ==========================================================
	// AXI4-Lite write channel and register updates
	assign wsel     = sfd_decode(aw_addr);
	assign do_write = aw_full && w_full && !S_AXI_BVALID;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r & mask;
	endfunction

	always_comb begin
		next_aw_full = aw_full;
		next_w_full  = w_full;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = S_AXI_BVALID;
		next_bresp   = S_AXI_BRESP;
		next_tcw     = tcw;
		next_mode    = mode_reg;
		next_ctrl    = ctrl_reg;
		next_rxsa    = rxsa_reg;
		next_cdsa    = cdsa_reg;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_full = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_full = 1'b1;
			next_w_data = S_AXI_WDATA;
			next_w_strb = S_AXI_WSTRB;
		end
		if (S_AXI_BVALID && S_AXI_BREADY)
			next_bvalid = 1'b0;
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			case (wsel)
				SEL_TCW:  if (long_frame)
					next_tcw = merge(tcw, w_data, w_strb, ~ZERO_W);
				SEL_MODE: next_mode = merge(mode_reg, w_data, w_strb,
					MODE_MASK);
				SEL_CTRL: next_ctrl = merge(ctrl_reg, w_data, w_strb,
					CTRL_MASK);
				SEL_RXSA: next_rxsa = merge(rxsa_reg, w_data, w_strb,
					SA_MASK);
				SEL_CDSA: next_cdsa = merge(cdsa_reg, w_data, w_strb,
					SA_MASK);
				default: ;
			endcase
		end
		if (next_mode[STOP_BIT])
			next_tcw = TCW_RST;
		next_awready = !next_aw_full && !next_bvalid;
		next_wready  = !next_w_full && !next_bvalid;
	end

	// ==========================================================
	// AXI4-Lite read channel
	assign rsel     = sfd_decode(S_AXI_ARADDR);
	assign fifo_pop = CE && S_AXI_ARVALID && S_AXI_ARREADY &&
		(rsel == SEL_RSW);

	always_comb begin
		next_rvalid  = S_AXI_RVALID;
		next_rdata   = S_AXI_RDATA;
		next_rresp   = S_AXI_RRESP;
		if (S_AXI_RVALID && S_AXI_RREADY)
			next_rvalid = 1'b0;
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case (rsel)
				SEL_RSW:  next_rdata = fifo_head;
				SEL_TCW:  next_rdata = tcw;
				SEL_RCW:  next_rdata = rcw;
				SEL_MODE: next_rdata = mode_reg;
				SEL_CTRL: next_rdata = ctrl_reg;
				SEL_RXSA: next_rdata = rxsa_reg;
				SEL_CDSA: next_rdata = cdsa_reg;
				default: begin
					next_rdata = ZERO_W;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	// ==========================================================
	// State registers, frozen while CE is low
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			tcw           <= TCW_RST;
			rcw           <= RCW_RST;
			mode_reg      <= ZERO_W;
			ctrl_reg      <= ZERO_W;
			rxsa_reg      <= ZERO_W;
			cdsa_reg      <= ZERO_W;
			left_hold     <= '0;
			right_hold    <= '0;
			rx_shift      <= '0;
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= ZERO_W;
			w_strb        <= '0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= RESP_OKAY;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= ZERO_W;
			S_AXI_RRESP   <= RESP_OKAY;
			SERIAL_TX_PIN <= 1'b1;
		end else if (CE) begin
			tcw           <= next_tcw;
			rcw           <= next_rcw;
			mode_reg      <= next_mode;
			ctrl_reg      <= next_ctrl;
			rxsa_reg      <= next_rxsa;
			cdsa_reg      <= next_cdsa;
			left_hold     <= next_left;
			right_hold    <= next_right;
			rx_shift      <= next_shift;
			aw_full       <= next_aw_full;
			w_full        <= next_w_full;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY  <= next_wready;
			S_AXI_BVALID  <= next_bvalid;
			S_AXI_BRESP   <= next_bresp;
			S_AXI_ARREADY <= next_arready;
			S_AXI_RVALID  <= next_rvalid;
			S_AXI_RDATA   <= next_rdata;
			S_AXI_RRESP   <= next_rresp;
			SERIAL_TX_PIN <= next_tx;
		end
	end
endmodule // sfd_top
`default_nettype wire

//--- sfd_asserts.sv
// Checker on the AXI4-Lite port and serial output of the data block
`timescale 1ns/1ps
`default_nettype none
module sfd_asserts
	import sfd_pkg::*;
(
	// Clock and reset
	input wire logic              CLK_SYS,
	input wire logic              RST_N,
	// AXI4-Lite
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic              S_AXI_AWVALID,
	input wire logic              S_AXI_AWREADY,
	input wire logic              S_AXI_WVALID,
	input wire logic              S_AXI_WREADY,
	input wire logic [1:0]        S_AXI_BRESP,
	input wire logic              S_AXI_BVALID,
	input wire logic              S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic              S_AXI_ARVALID,
	input wire logic              S_AXI_ARREADY,
	input wire logic [31:0]       S_AXI_RDATA,
	input wire logic [1:0]        S_AXI_RRESP,
	input wire logic              S_AXI_RVALID,
	input wire logic              S_AXI_RREADY,
	// Serial link
	input wire logic              SERIAL_TX_PIN
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	// ==========================================================
	// Handshake helpers
	logic aw_go;
	logic ar_go;
	logic aw_map;
	logic ar_map;
	assign aw_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY;
	assign ar_go = S_AXI_ARVALID && S_AXI_ARREADY;
	assign aw_map = S_AXI_AWADDR <= OFF_CDSA && S_AXI_AWADDR[1:0] == 2'h0;
	assign ar_map = S_AXI_ARADDR <= OFF_CDSA && S_AXI_ARADDR[1:0] == 2'h0;

	// ==========================================================
	// Properties
	a_bvalid_delay: assert property (aw_go |-> ##2 S_AXI_BVALID)
		else $error("write response late");
	a_bresp_code: assert property (aw_go |-> ##2
		S_AXI_BRESP == ($past(aw_map, 2) ? RESP_OKAY : RESP_SLVERR))
		else $error("write response code wrong");
	a_rresp_code: assert property (ar_go |=> S_AXI_RVALID &&
		S_AXI_RRESP == ($past(ar_map) ? RESP_OKAY : RESP_SLVERR))
		else $error("read response wrong");
	a_rdata_unmapped: assert property (ar_go && !ar_map |=>
		S_AXI_RDATA == ZERO_W) else $error("unmapped read data not zero");
	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
		else $error("read data dropped");
	a_aw_busy: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=>
		!S_AXI_AWREADY[*2]) else $error("write address ready too soon");
	a_ar_busy: assert property (ar_go |=> !S_AXI_ARREADY)
		else $error("read address ready too soon");
	a_tx_steady: assert property ($changed(SERIAL_TX_PIN) |=>
		$stable(SERIAL_TX_PIN)[*6]) else $error("tx pin changed too soon");
endmodule // sfd_asserts

bind sfd_top sfd_asserts i_sfd_asserts (.CLK_SYS, .RST_N, .S_AXI_AWADDR,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
	.S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
	.S_AXI_RVALID, .S_AXI_RREADY, .SERIAL_TX_PIN);
`default_nettype wire

//--- sfd_codec.sv
// Behavioural codec model on the serial link of the data block
`timescale 1ns/1ps
`default_nettype none
module sfd_codec (
	// Link outputs
	output var logic sclk,
	output var logic fsync,
	output var logic rxd,
	// Link input
	input  wire logic txd
);
	initial begin
		sclk = 1'b0;
		fsync = 1'b0;
		rxd = 1'b1;
	end

	// ==========================================================
	// One long frame, slot 0 first, MSB first; clock still outside
	task automatic frame(input logic [63:0] w, output logic [63:0] t);
		int i;
		#7;
		for (i = 63; i >= 0; i--) begin
			fsync = (i == 63);
			rxd = w[i];
			#160;
			sclk = 1'b1;
			t[i] = txd;
			#160;
			sclk = 1'b0;
		end
		fsync = 1'b0;
		// Released line never repeats the last bit
		rxd = ~rxd;
	endtask
endmodule // sfd_codec
`default_nettype wire

//--- sfd_top_test.sv
// Testbench of the serial data and control-data register block
`timescale 1ns/1ps
`default_nettype none
module sfd_top_test
	import sfd_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic        awv;
	logic        wv;
	logic        bry;
	logic        arv;
	logic        rry;
	logic [7:0]  awa;
	logic [7:0]  ara;
	logic [31:0] wd;
	logic [63:0] txf;
	wire         awr, wrdy, bv, arr, rv, tx, sclk, fs, rxd;
	wire  [1:0]  br, rr;
	wire  [31:0] rdat;
	int          mismatches;
	int          checks;

	sfd_top i_sfd_top (.CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .SERIAL_CLK(sclk),
		.FRAME_SYNC(fs), .SERIAL_RX_PIN(rxd), .SERIAL_TX_PIN(tx));
	sfd_codec i_sfd_codec (.sclk(sclk), .fsync(fs), .rxd(rxd), .txd(tx));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h", $time, msg, got);
		end
	endtask

	// Waits with no limit of its own: only the watchdog ends a hang
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (!bv);
		bry <= 1'b0;
		chk({30'h0, br}, {30'h0, er}, "write response");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rry <= 1'b0;
		chk(rdat, e, "read data");
		chk({30'h0, rr}, {30'h0, er}, "read response");
	endtask

	task automatic frm(input logic [63:0] w);
		i_sfd_codec.frame(w, txf);
		repeat (8) @(posedge clk);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		rst_n = 1'b0;
		{awv, wv, bry, arv, rry} = 5'h00;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0000_0000;
		mismatches = 0;
		checks = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(OFF_TCW, TCW_RST, RESP_OKAY);
		rd_chk(OFF_RCW, RCW_RST, RESP_OKAY);
		rd_chk(8'h1C, ZERO_W, RESP_SLVERR);
		wr_chk(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
		wr_chk(OFF_TCW, 32'h1357_9BDF, RESP_OKAY);
		rd_chk(OFF_TCW, ZERO_W, RESP_OKAY);
		$display("test reset and map done");
		wr_chk(OFF_MODE, 32'h0000_0008, RESP_OKAY);
		wr_chk(OFF_TCW, 32'hA5A5_3C3C, RESP_OKAY);
		rd_chk(OFF_TCW, 32'hA5A5_3C3C, RESP_OKAY);
		wr_chk(OFF_RCW, 32'hFFFF_FFFF, RESP_OKAY);
		rd_chk(OFF_RCW, ZERO_W, RESP_OKAY);
		wr_chk(OFF_CDSA, 32'h0000_8280, RESP_OKAY);
		wr_chk(OFF_RXSA, 32'h0000_8381, RESP_OKAY);
		wr_chk(OFF_CTRL, 32'h0000_0006, RESP_OKAY);
		frm(64'h1234_ABCD_5678_9ABC);
		chk(txf[63:32], 32'hA5A5_FFFF, "tx slots 0 1");
		chk(txf[31:0], 32'h3C3C_FFFF, "tx slots 2 3");
		frm(64'h1111_2222_3333_4444);
		rd_chk(OFF_RCW, 32'h1111_3333, RESP_OKAY);
		rd_chk(OFF_RSW, 32'hABCD_9ABC, RESP_OKAY);
		rd_chk(OFF_RSW, 32'h2222_4444, RESP_OKAY);
		$display("test frames done");
		frm(64'h5555_6666_7777_8888);
		wr_chk(OFF_CTRL, 32'h0000_0007, RESP_OKAY);
		rd_chk(OFF_RCW, ZERO_W, RESP_OKAY);
		wr_chk(OFF_CTRL, 32'h0000_0006, RESP_OKAY);
		frm(64'h0102_0304_0506_0708);
		rd_chk(OFF_RSW, 32'h0304_0708, RESP_OKAY);
		rd_chk(OFF_RCW, 32'h0102_0506, RESP_OKAY);
		$display("test receive reset done");
		wr_chk(OFF_MODE, 32'h0000_0108, RESP_OKAY);
		rd_chk(OFF_TCW, ZERO_W, RESP_OKAY);
		wr_chk(OFF_TCW, 32'hFFFF_0000, RESP_OKAY);
		rd_chk(OFF_TCW, ZERO_W, RESP_OKAY);
		$display("test module stop done");
		end_sim;
	end

	initial begin
		#1_000_000;
		mismatches++;
		$display("wrong value at %0t: watchdog expired", $time);
		end_sim;
	end
endmodule // sfd_top_test
`default_nettype wire
